// *** logic/scan_out_cfg.svh ***
// constants for the scan process output controller
`ifndef SCAN_OUT_CFG_SVH
`define SCAN_OUT_CFG_SVH
// ============================================================
// register offsets
`define REG_CTRL 8'h00
`define REG_DIGITAL 8'h04
`define REG_DIVIDER 8'h08
`define REG_DELAY_US 8'h0C
`define REG_SHIFT_BASE 8'h10
`define REG_FIELD_LIMIT 8'h14
`define REG_OBJ_LIMIT 8'h18
`define REG_LINE_COUNT 8'h1C
`define REG_DASH 8'h20
`define REG_ANA_MIN 8'h24
`define REG_ANA_MAX 8'h28
`define REG_COMMAND 8'h2C
`define REG_STATUS 8'h30
`define REG_FIELD_COUNT 8'h34
`define REG_OBJ_COUNT 8'h38
// ============================================================
// control register fields
`define CTRL_STEP_MODE 0
`define CTRL_PAUSE 1
`define CTRL_HOLD 2
`define CTRL_DASH 3
// digital register fields
`define DIG_NEG 0
`define DIG_SRC_LSB 1
`define DIG_SYNC_LSB 4
// command register fields (write one)
`define CMD_START 0
`define CMD_STOP 1
`define CMD_STEP 2
`define CMD_CONT 3
// ============================================================
// reset values and timing
`define DIVIDER_RST 16'h0001
`define CLK_MHZ 250
`define US_NS 1000
`define CLK_NS 4
`define CYC_PER_US (`US_NS / `CLK_NS)
`endif

// *** logic/scan_out_pkg.sv ***
// types for the scan process output controller
package scan_out_pkg;
  // ============================================================
  // output source selection
  typedef enum logic [2:0] {
    SRC_FREQ = 3'h0,
    SRC_RUN = 3'h1,
    SRC_SCAN = 3'h2,
    SRC_OBJ = 3'h3,
    SRC_POS = 3'h4
  } src_t;
  // process sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_RUN = 4'h2,
    ST_WAIT = 4'h4,
    ST_PAUSE = 4'h8
  } proc_state_t;
  // motion events from the scan engine
  typedef struct packed {
    logic revolution;
    logic facet;
    logic scan;
    logic object;
    logic line_done;
    logic galvo_jump;
    logic pos_tick;
  } motion_ev_t;
  // beam window flags
  typedef struct packed {
    logic in_field;
    logic in_object;
  } window_t;
endpackage : scan_out_pkg

// *** logic/delay_line.sv ***
// bit delay line memory with registered read data
module delay_line #(
  parameter int DEPTH = 4096,
  parameter int AW = 12
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic bit_in,
  input wire logic [AW-1:0] delay_in,
  output logic bit_out
);
  // ============================================================
  // circular buffer
  logic mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;

  // write pointer walks every cycle
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wr_ptr <= '0;
    end else begin
      wr_ptr <= wr_ptr + AW'(1);
    end
  end

  always_ff @(posedge clk_in) begin
    mem[wr_ptr] <= bit_in;
  end

  // read behind the writer; zero delay bypasses the memory
  assign rd_ptr = wr_ptr - delay_in;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      bit_out <= 1'b0;
    end else if (delay_in == '0) begin
      bit_out <= bit_in;
    end else begin
      bit_out <= mem[rd_ptr];
    end
  end
endmodule : delay_line

// *** logic/scan_process_output_control.sv ***
// process sequencer, digital output shaping and converter feeds
`include "scan_out_cfg.svh"
module scan_process_output_control
  import scan_out_pkg::*;
#(
  parameter int DELAY_DEPTH = 4096,
  parameter int DELAY_AW = 12
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  input wire logic [6:0] motion_in,
  input wire logic [1:0] window_in,
  input wire logic [31:0] bitmap_in,
  input wire logic pixel_on_in,
  output logic digital_out,
  output logic expose_out,
  output logic line_advance_out,
  output logic [15:0] upper_half_converter_feed_out,
  output logic [15:0] lower_half_converter_feed_out,
  output logic running_out
);
  // ============================================================
  // input synchronisers
  logic [6:0] mot_s1;
  logic [6:0] mot_s2;
  logic [6:0] mot_s3;
  logic [1:0] win_s1;
  logic [1:0] win_s2;
  motion_ev_t ev;
  window_t win;

  // two stages, third stage only for edge detection
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      mot_s1 <= '0;
      mot_s2 <= '0;
      mot_s3 <= '0;
      win_s1 <= '0;
      win_s2 <= '0;
    end else begin
      mot_s1 <= motion_in;
      mot_s2 <= mot_s1;
      mot_s3 <= mot_s2;
      win_s1 <= window_in;
      win_s2 <= win_s1;
    end
  end
  // events are rising edges of the synchronised levels
  assign ev = motion_ev_t'(mot_s2 & ~mot_s3);
  assign win = window_t'(win_s2);

  // ============================================================
  // registers
  logic [3:0] ctrl;
  logic [8:0] digital;
  logic [15:0] divider;
  logic [15:0] delay_us;
  logic [15:0] shift_base;
  logic [15:0] field_limit;
  logic [15:0] obj_limit;
  logic [15:0] line_count;
  logic [31:0] dash_length_and_gap;
  logic [15:0] ana_min;
  logic [15:0] ana_max;
  logic [15:0] field_count;
  logic [15:0] obj_count;
  logic cmd_start;
  logic cmd_stop;
  logic cmd_step;
  logic cmd_cont;
  src_t src;

  assign src = src_t'(digital[`DIG_SRC_LSB +: 3]);

  // configuration writes
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ctrl <= '0;
      digital <= '0;
      divider <= `DIVIDER_RST;
      delay_us <= '0;
      shift_base <= '0;
      field_limit <= '0;
      obj_limit <= '0;
      line_count <= '0;
      dash_length_and_gap <= '0;
      ana_min <= '0;
      ana_max <= 16'hFFFF;
    end else if (wr_in) begin
      if (addr_in == `REG_CTRL) begin
        ctrl <= wdata_in[3:0];
      end else if (addr_in == `REG_DIGITAL) begin
        digital <= wdata_in[8:0];
      end else if (addr_in == `REG_DIVIDER) begin
        divider <= wdata_in[15:0];
      end else if (addr_in == `REG_DELAY_US) begin
        delay_us <= wdata_in[15:0];
      end else if (addr_in == `REG_SHIFT_BASE) begin
        shift_base <= wdata_in[15:0];
      end else if (addr_in == `REG_FIELD_LIMIT) begin
        field_limit <= wdata_in[15:0];
      end else if (addr_in == `REG_OBJ_LIMIT) begin
        obj_limit <= wdata_in[15:0];
      end else if (addr_in == `REG_LINE_COUNT) begin
        line_count <= wdata_in[15:0];
      end else if (addr_in == `REG_DASH) begin
        dash_length_and_gap <= wdata_in;
      end else if (addr_in == `REG_ANA_MIN) begin
        ana_min <= wdata_in[15:0];
      end else if (addr_in == `REG_ANA_MAX) begin
        ana_max <= wdata_in[15:0];
      end
    end
  end

  // command pulses, one cycle
  assign cmd_start = wr_in && addr_in == `REG_COMMAND && wdata_in[`CMD_START];
  assign cmd_stop = wr_in && addr_in == `REG_COMMAND && wdata_in[`CMD_STOP];
  assign cmd_step = wr_in && addr_in == `REG_COMMAND && wdata_in[`CMD_STEP];
  assign cmd_cont = wr_in && addr_in == `REG_COMMAND && wdata_in[`CMD_CONT];

  // ============================================================
  // process sequencer
  proc_state_t state;
  logic [15:0] rep_cnt;
  logic limit_hit;
  logic line_end;
  logic last_rep;
  logic step_mode;
  logic hold;

  assign step_mode = ctrl[`CTRL_STEP_MODE];
  assign hold = ctrl[`CTRL_HOLD] && step_mode;
  assign last_rep = rep_cnt + 16'h0001 >= line_count;
  assign line_end = ev.line_done && (state == ST_RUN);
  // limits of zero mean unlimited
  assign limit_hit = (field_limit != '0 && ev.scan &&
                      field_count + 16'h0001 >= field_limit) ||
                     (obj_limit != '0 && ev.object &&
                      obj_count + 16'h0001 >= obj_limit);

  // main state machine
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state <= ST_IDLE;
    end else if (cmd_stop || (state != ST_IDLE && limit_hit)) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (cmd_start) begin
            state <= step_mode ? ST_WAIT : ST_RUN;
          end
        end
        ST_RUN: begin
          if (ev.galvo_jump && ctrl[`CTRL_PAUSE]) begin
            state <= ST_PAUSE;
          end else if (line_end && step_mode && last_rep) begin
            state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (cmd_step) begin
            state <= ST_RUN;
          end
        end
        ST_PAUSE: begin
          if (cmd_cont || cmd_step) begin
            state <= ST_RUN;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // line repeat counter
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || state == ST_IDLE) begin
      rep_cnt <= '0;
    end else if (line_end) begin
      rep_cnt <= (last_rep || hold) ? 16'h0000 : rep_cnt + 16'h0001;
    end
  end

  // hold keeps the galvo on the same line
  assign line_advance_out = line_end && last_rep && !hold;
  assign running_out = state != ST_IDLE;

  // exposure counters, cleared at start
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || cmd_start) begin
      field_count <= '0;
      obj_count <= '0;
    end else if (state != ST_IDLE) begin
      if (ev.scan) begin
        field_count <= field_count + 16'h0001;
      end
      if (ev.object) begin
        obj_count <= obj_count + 16'h0001;
      end
    end
  end

  // ============================================================
  // dash pattern along the fast axis
  logic [15:0] dash_cnt;
  logic [15:0] dash_len;
  logic [15:0] dash_gap;
  assign dash_len = dash_length_and_gap[15:0];
  assign dash_gap = dash_length_and_gap[31:16];

  // counter restarts at each line so dashes line up
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || ev.line_done) begin
      dash_cnt <= '0;
    end else if (ev.pos_tick) begin
      dash_cnt <= (dash_cnt + 16'h0001 >= dash_len + dash_gap) ?
                  16'h0000 : dash_cnt + 16'h0001;
    end
  end

  // exposure gate
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      expose_out <= 1'b0;
    end else begin
      expose_out <= state == ST_RUN && win.in_object && pixel_on_in &&
                    (!ctrl[`CTRL_DASH] || dash_cnt < dash_len);
    end
  end

  // ============================================================
  // digital output generator
  logic sync_hit;
  logic [15:0] div_cnt;
  logic [15:0] shape_cnt;
  logic freq_q;
  logic src_bit;
  logic pre_delay;
  logic adv;
  logic [DELAY_AW-1:0] delay_cyc;

  // any enabled sync event restarts the generator
  assign sync_hit = (digital[`DIG_SYNC_LSB] && cmd_start) ||
                    (digital[`DIG_SYNC_LSB+1] && ev.revolution) ||
                    (digital[`DIG_SYNC_LSB+2] && ev.facet) ||
                    (digital[`DIG_SYNC_LSB+3] && ev.scan) ||
                    (digital[`DIG_SYNC_LSB+4] && ev.object);
  // clock steps for freq, position ticks for pos
  assign adv = (src == SRC_POS) ? ev.pos_tick : 1'b1;

  // divider shared by both frequency sources
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || sync_hit) begin
      div_cnt <= '0;
      freq_q <= 1'b0;
      shape_cnt <= '0;
    end else if (adv) begin
      if (div_cnt + 16'h0001 >= divider) begin
        div_cnt <= '0;
        // shift base sets how many half periods per pattern
        if (shape_cnt + 16'h0001 >= shift_base) begin
          shape_cnt <= '0;
          freq_q <= 1'b0;
        end else begin
          shape_cnt <= shape_cnt + 16'h0001;
          freq_q <= ~freq_q;
        end
      end else begin
        div_cnt <= div_cnt + 16'h0001;
      end
    end
  end

  // source multiplexer
  always_comb begin
    case (src)
      SRC_FREQ: src_bit = freq_q;
      SRC_RUN: src_bit = state != ST_IDLE;
      SRC_SCAN: src_bit = win.in_field;
      SRC_OBJ: src_bit = win.in_object;
      SRC_POS: src_bit = freq_q;
      default: src_bit = 1'b0;
    endcase
  end

  // inversion sits ahead of the delay
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pre_delay <= 1'b0;
    end else begin
      pre_delay <= src_bit ^ digital[`DIG_NEG];
    end
  end

  // delay saturates at one cycle below the memory depth
  assign delay_cyc = (delay_us * `CYC_PER_US >= DELAY_DEPTH) ?
                     DELAY_AW'(DELAY_DEPTH - 1) :
                     DELAY_AW'(delay_us * `CYC_PER_US);

  delay_line #(
    .DEPTH(DELAY_DEPTH),
    .AW(DELAY_AW)
  ) u_delay (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .bit_in(pre_delay),
    .delay_in(delay_cyc),
    .bit_out(digital_out)
  );

  // ============================================================
  // converter feeds scaled between min and max
  function automatic logic [15:0] scale(input logic [15:0] v,
                                        input logic [15:0] lo,
                                        input logic [15:0] hi);
    logic [31:0] p;
    p = 32'(v) * 32'(hi - lo);
    return lo + p[31:16];
  endfunction : scale

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      upper_half_converter_feed_out <= '0;
      lower_half_converter_feed_out <= '0;
    end else begin
      upper_half_converter_feed_out <=
        scale(bitmap_in[31:16], ana_min, ana_max);
      lower_half_converter_feed_out <=
        scale(bitmap_in[15:0], ana_min, ana_max);
    end
  end

  // ============================================================
  // read back, unmapped reads zero
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rdata_out <= '0;
    end else if (rd_in) begin
      if (addr_in == `REG_CTRL) begin
        rdata_out <= {28'h0000000, ctrl};
      end else if (addr_in == `REG_DIGITAL) begin
        rdata_out <= {23'h0, digital};
      end else if (addr_in == `REG_DIVIDER) begin
        rdata_out <= {16'h0000, divider};
      end else if (addr_in == `REG_DELAY_US) begin
        rdata_out <= {16'h0000, delay_us};
      end else if (addr_in == `REG_SHIFT_BASE) begin
        rdata_out <= {16'h0000, shift_base};
      end else if (addr_in == `REG_FIELD_LIMIT) begin
        rdata_out <= {16'h0000, field_limit};
      end else if (addr_in == `REG_OBJ_LIMIT) begin
        rdata_out <= {16'h0000, obj_limit};
      end else if (addr_in == `REG_LINE_COUNT) begin
        rdata_out <= {16'h0000, line_count};
      end else if (addr_in == `REG_DASH) begin
        rdata_out <= dash_length_and_gap;
      end else if (addr_in == `REG_ANA_MIN) begin
        rdata_out <= {16'h0000, ana_min};
      end else if (addr_in == `REG_ANA_MAX) begin
        rdata_out <= {16'h0000, ana_max};
      end else if (addr_in == `REG_STATUS) begin
        rdata_out <= {28'h0000000, state};
      end else if (addr_in == `REG_FIELD_COUNT) begin
        rdata_out <= {16'h0000, field_count};
      end else if (addr_in == `REG_OBJ_COUNT) begin
        rdata_out <= {16'h0000, obj_count};
      end else begin
        rdata_out <= '0;
      end
    end else begin
      rdata_out <= '0;
    end
  end
endmodule : scan_process_output_control

// *** testbench/scan_motion_model.sv ***
// far side model: scan engine motion event lines
module scan_motion_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [6:0] ev_req_in,
  output logic [6:0] motion_out
);
  logic [6:0] r1, r2, r3;
  // ========
  // each request holds its line three cycles so both sync flops see it
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      r1 <= 7'h00;
      r2 <= 7'h00;
      r3 <= 7'h00;
    end else begin
      r1 <= ev_req_in;
      r2 <= r1;
      r3 <= r2;
    end
  end
  assign motion_out = r1 | r2 | r3;
endmodule : scan_motion_model

// *** testbench/scan_out_monitor.sv ***
// assertion checker for the scan process output controller
`include "scan_out_cfg.svh"
module scan_out_monitor (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic [1:0] window_in,
  input wire logic [31:0] bitmap_in,
  input wire logic digital_out,
  input wire logic [15:0] upper_half_converter_feed_out,
  input wire logic [15:0] lower_half_converter_feed_out,
  input wire logic running_out
);
  logic [3:0] dig;
  logic [15:0] dly, amin, amax;
  logic [2:0] quiet;
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  // ========
  // shadow of the settings the outputs depend on
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      dig <= 4'h0;
      dly <= 16'h0000;
      amin <= 16'h0000;
      amax <= 16'hFFFF;
    end else if (wr_in) begin
      case (addr_in)
        `REG_DIGITAL: dig <= wdata_in[3:0];
        `REG_DELAY_US: dly <= wdata_in[15:0];
        `REG_ANA_MIN: amin <= wdata_in[15:0];
        `REG_ANA_MAX: amax <= wdata_in[15:0];
        default: ;
      endcase
    end
  end
  // cycles since the output setup changed: pipeline must refill first
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || (wr_in && (addr_in == `REG_DIGITAL ||
        addr_in == `REG_DELAY_US))) begin
      quiet <= 3'h0;
    end else if (quiet != 3'h7) begin
      quiet <= quiet + 3'h1;
    end
  end
  function automatic logic [15:0] scale(input logic [15:0] v,
    input logic [15:0] lo, input logic [15:0] hi);
    logic [31:0] p;
    p = {16'h0000, v} * {16'h0000, hi - lo};
    return lo + p[31:16];
  endfunction : scale
  // ========
  // sequencer and output relations
  property p_start_runs;
    wr_in && addr_in == `REG_COMMAND && wdata_in[1:0] == 2'h1
      |=> running_out;
  endproperty
  a_start_runs: assert property (p_start_runs)
    else $error("start did not set running");
  property p_stop_idles;
    wr_in && addr_in == `REG_COMMAND && wdata_in[1] |=> !running_out;
  endproperty
  a_stop_idles: assert property (p_stop_idles)
    else $error("stop did not end the process");
  property p_idle_stays;
    !running_out && !(wr_in && addr_in == `REG_COMMAND) |=> !running_out;
  endproperty
  a_idle_stays: assert property (p_idle_stays)
    else $error("process began without start");
  property p_run_level;
    dig[3:1] == 3'h1 && dly == 16'h0000 && quiet > 3'h2
      |-> digital_out == ($past(running_out, 2) ^ dig[0]);
  endproperty
  a_run_level: assert property (p_run_level)
    else $error("run level output wrong");
  property p_scan_win;
    dig[3:1] == 3'h2 && dly == 16'h0000 && quiet > 3'h4
      |-> digital_out == ($past(window_in[1], 4) ^ dig[0]);
  endproperty
  a_scan_win: assert property (p_scan_win)
    else $error("scan window output wrong");
  property p_obj_win;
    dig[3:1] == 3'h3 && dly == 16'h0000 && quiet > 3'h4
      |-> digital_out == ($past(window_in[0], 4) ^ dig[0]);
  endproperty
  a_obj_win: assert property (p_obj_win)
    else $error("object window output wrong");
  property p_upper;
    $past(rst_n_in) && $past(amax) >= $past(amin)
      |-> upper_half_converter_feed_out ==
        scale($past(bitmap_in[31:16]), $past(amin), $past(amax));
  endproperty
  a_upper: assert property (p_upper)
    else $error("upper converter feed wrong");
  property p_lower;
    $past(rst_n_in) && $past(amax) >= $past(amin)
      |-> lower_half_converter_feed_out ==
        scale($past(bitmap_in[15:0]), $past(amin), $past(amax));
  endproperty
  a_lower: assert property (p_lower)
    else $error("lower converter feed wrong");
endmodule : scan_out_monitor
bind scan_process_output_control scan_out_monitor mon (
  .clk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in, .window_in,
  .bitmap_in, .digital_out, .upper_half_converter_feed_out,
  .lower_half_converter_feed_out, .running_out
);

// *** testbench/scan_process_output_control_tb_top.sv ***
// self-checking bench for the scan process output controller
`include "scan_out_cfg.svh"
`define CHECK(nm, e, g) \
  tests_run++; \
  if ((g) !== (e)) begin \
    err_count++; \
    $display("wrong value %s exp %0h got %0h", nm, e, g); \
  end
module scan_process_output_control_tb_top import scan_out_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] addr_in = 8'h00;
  logic [31:0] wdata_in = 32'h0;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [6:0] ev_req = 7'h00;
  logic [1:0] window_in = 2'h0;
  logic [31:0] bitmap_in = 32'h0;
  logic pixel_on_in = 1'b1;
  logic expose, line_adv;
  logic [31:0] rdata_out;
  logic [6:0] motion_in;
  logic digital_out, running_out;
  logic [15:0] upper_feed, lower_feed;
  int err_count = 0;
  int tests_run = 0;
  int adv_cnt = 0;
  // delay memory kept short: one microsecond still fits
  scan_process_output_control #(.DELAY_DEPTH(512), .DELAY_AW(9)) dut (
    .clk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .motion_in, .window_in, .bitmap_in, .pixel_on_in, .digital_out,
    .expose_out(expose), .line_advance_out(line_adv),
    .upper_half_converter_feed_out(upper_feed),
    .lower_half_converter_feed_out(lower_feed), .running_out);
  scan_motion_model model (.clk_in, .rst_n_in, .ev_req_in(ev_req),
    .motion_out(motion_in));
  // ========
  // 250 MHz clock
  initial begin
    forever #2 clk_in = ~clk_in;
  end
  // advance is a one-cycle pulse, too short for a task to catch
  always @(posedge clk_in) begin
    if (line_adv) begin
      adv_cnt <= adv_cnt + 1;
    end
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report
  // ========
  // bus cycles; a gap cycle keeps strobes from being set twice at one edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    @(posedge clk_in);
  endtask : wr
  task automatic expect_reg(input logic [7:0] a, input logic [31:0] e);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    `CHECK($sformatf("reg %0h", a), e, rdata_out)
    @(posedge clk_in);
  endtask : expect_reg
  task automatic pulse(input int b);
    ev_req[b] <= 1'b1;
    @(posedge clk_in);
    ev_req[b] <= 1'b0;
    repeat (7) @(posedge clk_in);
  endtask : pulse
  // sample on falling edges, hand back on a rising one for the next drive
  task automatic wait_lvl(input logic v, output int n);
    n = 0;
    do begin
      @(negedge clk_in);
      n++;
      if (n > 600) begin
        err_count++;
        $display("wrong value output wait exp %0b got timeout", v);
        final_report();
      end
    end while (digital_out !== v);
    @(posedge clk_in);
  endtask : wait_lvl
  // ========
  // scenarios
  task automatic t_limit(input logic [7:0] a, input int b);
    wr(`REG_CTRL, 32'h0);
    wr(a, 32'h2);
    wr(`REG_COMMAND, 32'h1);
    pulse(b);
    expect_reg(`REG_STATUS, 32'(ST_RUN));
    pulse(b);
    expect_reg(`REG_STATUS, 32'(ST_IDLE));
    wr(a, 32'h0);
    $display("test limit %0h done", a);
  endtask : t_limit
  task automatic t_latency(input logic [15:0] us, input logic ng);
    int n;
    wr(`REG_DIGITAL, {28'h0, 3'h1, ng});
    wr(`REG_DELAY_US, {16'h0, us});
    repeat (300) @(posedge clk_in);
    wr(`REG_COMMAND, 32'h1);
    wait_lvl(~ng, n);
    `CHECK("output delay", 2 + us * `CYC_PER_US, n)
    wr(`REG_COMMAND, 32'h2);
    $display("test latency %0d done", us);
  endtask : t_latency
  task automatic t_freq(input logic [15:0] div);
    int n;
    wr(`REG_DIVIDER, {16'h0, div});
    wait_lvl(1'b0, n);
    wait_lvl(1'b1, n);
    wait_lvl(1'b0, n);
    `CHECK("freq high width", div, n)
    $display("test freq %0d done", div);
  endtask : t_freq
  // dash of one tick, gap of two ticks, then a dark pixel
  task automatic t_dash();
    wr(`REG_CTRL, 32'h8);
    wr(`REG_DASH, 32'h0002_0001);
    wr(`REG_COMMAND, 32'h1);
    pulse(2);
    `CHECK("dash on", 1'b1, expose)
    pulse(0);
    `CHECK("dash gap", 1'b0, expose)
    pulse(0);
    pulse(0);
    `CHECK("dash again", 1'b1, expose)
    pixel_on_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    `CHECK("dash pixel off", 1'b0, expose)
    pixel_on_in <= 1'b1;
    wr(`REG_COMMAND, 32'h2);
    $display("test dash done");
  endtask : t_dash
  initial begin
    repeat (6) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    expect_reg(`REG_DIVIDER, 32'h1);
    expect_reg(`REG_ANA_MAX, 32'hFFFF);
    expect_reg(`REG_STATUS, 32'(ST_IDLE));
    expect_reg(8'h3C, 32'h0);
    wr(`REG_DIGITAL, 32'h2);
    wr(`REG_COMMAND, 32'h1);
    expect_reg(`REG_STATUS, 32'(ST_RUN));
    wr(`REG_COMMAND, 32'h2);
    expect_reg(`REG_STATUS, 32'(ST_IDLE));
    // step mode with two passes per line
    wr(`REG_CTRL, 32'h1);
    wr(`REG_LINE_COUNT, 32'h2);
    wr(`REG_COMMAND, 32'h1);
    expect_reg(`REG_STATUS, 32'(ST_WAIT));
    wr(`REG_COMMAND, 32'h4);
    pulse(2);
    expect_reg(`REG_STATUS, 32'(ST_RUN));
    `CHECK("line advance", 0, adv_cnt)
    pulse(2);
    expect_reg(`REG_STATUS, 32'(ST_WAIT));
    `CHECK("line advance", 1, adv_cnt)
    wr(`REG_COMMAND, 32'h2);
    // hold in step mode keeps the same line
    wr(`REG_CTRL, 32'h5);
    wr(`REG_COMMAND, 32'h1);
    wr(`REG_COMMAND, 32'h4);
    pulse(2);
    pulse(2);
    expect_reg(`REG_STATUS, 32'(ST_RUN));
    `CHECK("held line advance", 1, adv_cnt)
    wr(`REG_COMMAND, 32'h2);
    // pause after a slow axis jump
    wr(`REG_CTRL, 32'h2);
    wr(`REG_COMMAND, 32'h1);
    pulse(1);
    expect_reg(`REG_STATUS, 32'(ST_PAUSE));
    wr(`REG_COMMAND, 32'h8);
    expect_reg(`REG_STATUS, 32'(ST_RUN));
    wr(`REG_COMMAND, 32'h2);
    $display("test sequencer done");
    t_limit(`REG_FIELD_LIMIT, 4);
    t_limit(`REG_OBJ_LIMIT, 3);
    t_latency(16'h0, 1'b0);
    t_latency(16'h1, 1'b1);
    wr(`REG_DELAY_US, 32'h0);
    wr(`REG_SHIFT_BASE, 32'h8);
    wr(`REG_DIGITAL, 32'h0);
    t_freq(16'h3);
    t_freq(16'h5);
    wr(`REG_SHIFT_BASE, 32'h1);
    repeat (12) @(posedge clk_in);
    for (int i = 0; i < 20; i++) begin
      @(posedge clk_in);
      `CHECK("shift one output", 1'b0, digital_out)
    end
    // position source: scan sync clears, two ticks per toggle
    wr(`REG_SHIFT_BASE, 32'h8);
    wr(`REG_DIVIDER, 32'h2);
    wr(`REG_DIGITAL, 32'h88);
    pulse(4);
    pulse(0);
    `CHECK("pos one tick", 1'b0, digital_out)
    pulse(0);
    `CHECK("pos two ticks", 1'b1, digital_out)
    pulse(4);
    `CHECK("scan sync output", 1'b0, digital_out)
    // object sync: raise the output again, then clear it
    wr(`REG_DIGITAL, 32'h108);
    pulse(0);
    pulse(0);
    `CHECK("pos high again", 1'b1, digital_out)
    pulse(3);
    `CHECK("object sync output", 1'b0, digital_out)
    for (int s = 2; s < 4; s++) begin
      wr(`REG_DIGITAL, 32'(s << 1));
      for (int v = 0; v < 4; v++) begin
        window_in <= v[1:0];
        repeat (6) @(posedge clk_in);
        `CHECK("window output", v[3 - s], digital_out)
      end
    end
    t_dash();
    wr(`REG_ANA_MIN, 32'h1000);
    wr(`REG_ANA_MAX, 32'h3000);
    bitmap_in <= 32'h8000_4000;
    repeat (2) @(posedge clk_in);
    `CHECK("upper feed", 16'h2000, upper_feed)
    `CHECK("lower feed", 16'h1800, lower_feed)
    $display("test output shaping done");
    final_report();
  end
endmodule : scan_process_output_control_tb_top
